// ===== asi_active_image.sv
// asi_active_image: active copies of the control and range settings.
// assumes the serial register engine presents reads on a simple strobe
// port, and that pending values and refresh come from the control bank.
`timescale 1ns/100ps

module asi_active_image
  import asi_pkg::*;
#(
  parameter int NUM_CHANNELS = 4,
  parameter int VALID_CYCLES = ASI_VALID_CYCLES
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  // pending settings and refresh
  input  wire logic [15:0] i_pend_ctrl,
  input  wire logic [15:0] i_pend_range,
  input  wire logic        i_refresh,
  input  wire logic        i_cycle_done,
  // pins and pointer control
  input  wire logic        i_pin1_level,
  input  wire logic        i_pin2_level,
  input  wire logic        i_no_skip,
  // register read port
  input  wire logic        i_rd_en,
  input  wire logic [7:0]  i_rd_addr,
  output logic [15:0]      o_rd_data,
  output logic             o_rd_ack,
  // active settings
  output logic [15:0]      o_ctrl_image,
  output logic [15:0]      o_range_image,
  output logic             o_image_valid,
  output logic             o_rate_change_pending,
  // decoded mode
  output logic             o_adaptive,
  output logic             o_continuous,
  output logic             o_single,
  output logic             o_single_8x,
  output logic             o_fast,
  output logic             o_burst,
  output logic             o_sleep,
  output logic [1:0]       o_rate,
  // pins and channels
  output logic [1:0]       o_pin1_role,
  output logic [1:0]       o_pin2_role,
  output logic             o_pin1_gpio,
  output logic             o_pin2_gpio,
  output logic [3:0]       o_ch_active,
  output logic [3:0]       o_addr_skip
);

  // ----------------------------------------------------------------
  // variant defaults
  // ----------------------------------------------------------------
  localparam logic [3:0] CHOFF_RST =
    (NUM_CHANNELS >= 4) ? 4'h0 :
    (NUM_CHANNELS == 3) ? 4'h1 :
    (NUM_CHANNELS == 2) ? 4'h3 : 4'h7;
  localparam logic [15:0] CTRL_RST =
    ASI_CTRL_RST | (16'(CHOFF_RST) << ASI_CHOFF_LSB);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic [15:0] range_q;
  logic [15:0] defer_q;
  logic        defer_pend_q;
  logic        seen_refresh_q;
  logic [15:0] rd_data_q;
  logic        rd_ack_q;
  logic        adaptive_q;
  logic        continuous_q;
  logic        single_q;
  logic        single_8x_q;
  logic        fast_q;
  logic        burst_q;
  logic        sleep_q;
  logic [1:0]  rate_q;
  logic [3:0]  ch_active_q;
  logic [3:0]  addr_skip_q;
  logic        pin1_gpio_q;
  logic        pin2_gpio_q;

  // ----------------------------------------------------------------
  // refresh handling
  // ----------------------------------------------------------------
  wire [15:0] pend_ctrl_m = i_pend_ctrl & ASI_CTRL_MASK;
  wire [3:0]  act_mode    = ctrl_q[ASI_MODE_LSB +: 4];
  wire [3:0]  new_mode    = pend_ctrl_m[ASI_MODE_LSB +: 4];
  // a sleeping device ends no cycle, so its rate change needs no wait
  wire        rate_change = (new_mode != act_mode) &&
                            (act_mode != ASI_MODE_SLEEP);
  wire        defer_now   = i_refresh && rate_change;
  wire        apply_now   = i_refresh && !rate_change;
  wire        apply_defer = !i_refresh && defer_pend_q && i_cycle_done;
  wire [15:0] ctrl_d      = apply_now ? pend_ctrl_m : defer_q;

  // whole-word loads: no read can see a half-updated image
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= CTRL_RST;
    end else if (apply_now || apply_defer) begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      defer_q      <= CTRL_RST;
      defer_pend_q <= 1'b0;
    end else if (defer_now) begin
      defer_q      <= pend_ctrl_m;
      defer_pend_q <= 1'b1;
    end else if (apply_now || apply_defer) begin
      defer_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      range_q <= ASI_RANGE_RST;
    end else if (i_refresh) begin
      range_q <= i_pend_range;
    end
  end

  // ----------------------------------------------------------------
  // validity after refresh
  // ----------------------------------------------------------------
  logic timer_done;

  // one cycle short, the valid flop adds the last one
  asi_delay_timer #(
    .CYCLES (VALID_CYCLES - 1)
  ) u_valid_timer (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_start  (i_refresh),
    .o_done   (timer_done)
  );

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      seen_refresh_q <= 1'b0;
    end else if (i_refresh) begin
      seen_refresh_q <= 1'b1;
    end
  end

  // valid only once the delay ran out and no rate change still waits
  wire valid_d = seen_refresh_q && timer_done && !defer_pend_q;

  logic valid_q;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_d && !i_refresh;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic       dec_adaptive;
  logic       dec_continuous;
  logic [1:0] dec_rate;
  logic       dec_single;
  logic       dec_single_8x;
  logic       dec_fast;
  logic       dec_burst;
  logic       dec_sleep;

  asi_mode_decode u_mode_decode (
    .i_code       (act_mode),
    .o_adaptive   (dec_adaptive),
    .o_continuous (dec_continuous),
    .o_rate       (dec_rate),
    .o_single     (dec_single),
    .o_single_8x  (dec_single_8x),
    .o_fast       (dec_fast),
    .o_burst      (dec_burst),
    .o_sleep      (dec_sleep),
    .o_reserved   ()
  );

  // ----------------------------------------------------------------
  // pin roles, rate override and channels
  // ----------------------------------------------------------------
  wire [1:0] pin2_role_sel = ctrl_q[ASI_PIN2_LSB +: 2];
  wire [1:0] pin1_role_sel = ctrl_q[ASI_PIN1_LSB +: 2];
  wire [3:0] ch_off        = ctrl_q[ASI_CHOFF_LSB +: 4];
  wire       slow_force    =
    ((pin1_role_sel == ASI_PIN_SLOW) && i_pin1_level) ||
    ((pin2_role_sel == ASI_PIN_SLOW) && i_pin2_level);
  // override applies to rated modes only; sleep keeps sampling off
  wire       rated         = dec_adaptive || dec_continuous;
  wire [1:0] rate_d        = (slow_force && rated) ? ASI_RATE_8SPS : dec_rate;

  // data of a general pin is kept in the separate data register
  wire pin1_gpio = (pin1_role_sel == ASI_PIN_GP_IN) ||
                   (pin1_role_sel == ASI_PIN_GP_OUT);
  wire pin2_gpio = (pin2_role_sel == ASI_PIN_GP_IN) ||
                   (pin2_role_sel == ASI_PIN_GP_OUT);

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      adaptive_q   <= 1'b0;
      continuous_q <= 1'b0;
      single_q     <= 1'b0;
      single_8x_q  <= 1'b0;
      fast_q       <= 1'b0;
      burst_q      <= 1'b0;
      sleep_q      <= 1'b0;
      rate_q       <= 2'h0;
    end else begin
      adaptive_q   <= dec_adaptive;
      continuous_q <= dec_continuous;
      single_q     <= dec_single;
      single_8x_q  <= dec_single_8x;
      fast_q       <= dec_fast;
      burst_q      <= dec_burst;
      sleep_q      <= dec_sleep;
      rate_q       <= rate_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < ASI_NUM_CH; g++) begin : g_ch
      // field bit 7 is channel 1, bit 4 is channel 4
      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          ch_active_q[g] <= 1'b0;
          addr_skip_q[g] <= 1'b0;
        end else begin
          ch_active_q[g] <= !ch_off[ASI_NUM_CH-1-g];
          addr_skip_q[g] <= ch_off[ASI_NUM_CH-1-g] && !i_no_skip;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  wire hit_ctrl  = (i_rd_addr == ASI_OFS_ACT_CTRL);
  wire hit_range = (i_rd_addr == ASI_OFS_ACT_RANGE);
  wire [15:0] rd_mux = hit_ctrl  ? (ctrl_q & ASI_CTRL_MASK) :
                       hit_range ? range_q : 16'h0000;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_data_q <= 16'h0000;
      rd_ack_q  <= 1'b0;
    end else begin
      rd_ack_q  <= i_rd_en;
      if (i_rd_en) begin
        rd_data_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rd_data             = rd_data_q;
  assign o_rd_ack              = rd_ack_q;
  assign o_ctrl_image          = ctrl_q;
  assign o_range_image         = range_q;
  assign o_image_valid         = valid_q;
  assign o_rate_change_pending = defer_pend_q;
  assign o_adaptive            = adaptive_q;
  assign o_continuous          = continuous_q;
  assign o_single              = single_q;
  assign o_single_8x           = single_8x_q;
  assign o_fast                = fast_q;
  assign o_burst               = burst_q;
  assign o_sleep               = sleep_q;
  assign o_rate                = rate_q;
  assign o_pin1_role           = ctrl_q[ASI_PIN1_LSB +: 2];
  assign o_pin2_role           = ctrl_q[ASI_PIN2_LSB +: 2];
  assign o_pin1_gpio           = pin1_gpio_q;
  assign o_pin2_gpio           = pin2_gpio_q;
  assign o_ch_active           = ch_active_q;
  assign o_addr_skip           = addr_skip_q;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pin1_gpio_q <= 1'b0;
      pin2_gpio_q <= 1'b0;
    end else begin
      pin1_gpio_q <= pin1_gpio;
      pin2_gpio_q <= pin2_gpio;
    end
  end

endmodule : asi_active_image

// ===== asi_pkg.sv
// asi_pkg: constants and types shared by the active settings image block.
// assumes a 100 MHz core clock and an 8-bit register address space.
package asi_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ASI_OFS_PEND_CTRL   = 8'h01;
  localparam logic [7:0] ASI_OFS_PEND_RANGE  = 8'h1D;
  localparam logic [7:0] ASI_OFS_ACT_CTRL    = 8'h21;
  localparam logic [7:0] ASI_OFS_ACT_RANGE   = 8'h22;

  // ----------------------------------------------------------------
  // field positions of the active control image
  // ----------------------------------------------------------------
  localparam int ASI_MODE_LSB    = 12;
  localparam int ASI_PIN2_LSB    = 10;
  localparam int ASI_PIN1_LSB    = 8;
  localparam int ASI_CHOFF_LSB   = 4;
  localparam int ASI_NUM_CH      = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ASI_CTRL_RST   = 16'h0700;
  localparam logic [15:0] ASI_RANGE_RST  = 16'h0000;
  localparam logic [15:0] ASI_CTRL_MASK  = 16'hFFF0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int ASI_CLK_PERIOD_NS = 10;
  localparam int ASI_VALID_TIME_MS = 1;
  localparam int ASI_VALID_CYCLES  = (ASI_VALID_TIME_MS * 1000000) / ASI_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ASI_MODE_ADAPT_1024 = 4'h0,
    ASI_MODE_ADAPT_256  = 4'h1,
    ASI_MODE_ADAPT_64   = 4'h2,
    ASI_MODE_ADAPT_8    = 4'h3,
    ASI_MODE_CONT_1024  = 4'h4,
    ASI_MODE_CONT_256   = 4'h5,
    ASI_MODE_CONT_64    = 4'h6,
    ASI_MODE_CONT_8     = 4'h7,
    ASI_MODE_SINGLE     = 4'h8,
    ASI_MODE_SINGLE_8X  = 4'h9,
    ASI_MODE_FAST       = 4'hA,
    ASI_MODE_BURST      = 4'hB,
    ASI_MODE_SLEEP      = 4'hF
  } asi_mode_e;

  typedef enum logic [1:0] {
    ASI_PIN_ALERT  = 2'h0,
    ASI_PIN_GP_IN  = 2'h1,
    ASI_PIN_GP_OUT = 2'h2,
    ASI_PIN_SLOW   = 2'h3
  } asi_pin_role_e;

  // rate index: 0 = 1024, 1 = 256, 2 = 64, 3 = 8 samples per second
  localparam logic [1:0] ASI_RATE_8SPS = 2'h3;

endpackage : asi_pkg

// ===== asi_mode_decode.sv
// asi_mode_decode: combinational split of the sampling-mode code.
// assumes the caller registers every output it passes on.
`timescale 1ns/100ps
module asi_mode_decode
  import asi_pkg::*;
(
  // mode code
  input  wire logic [3:0] i_code,
  // decoded mode
  output logic            o_adaptive,
  output logic            o_continuous,
  output logic [1:0]      o_rate,
  output logic            o_single,
  output logic            o_single_8x,
  output logic            o_fast,
  output logic            o_burst,
  output logic            o_sleep,
  output logic            o_reserved
);

  // exactly one flag is high for any code, o_reserved alone for codes C to E
  always_comb begin
    o_adaptive   = 1'b0;
    o_continuous = 1'b0;
    o_rate       = i_code[1:0];
    o_single     = 1'b0;
    o_single_8x  = 1'b0;
    o_fast       = 1'b0;
    o_burst      = 1'b0;
    o_sleep      = 1'b0;
    o_reserved   = 1'b0;
    case (i_code)
      ASI_MODE_ADAPT_1024, ASI_MODE_ADAPT_256,
      ASI_MODE_ADAPT_64,   ASI_MODE_ADAPT_8:   o_adaptive   = 1'b1;
      ASI_MODE_CONT_1024,  ASI_MODE_CONT_256,
      ASI_MODE_CONT_64,    ASI_MODE_CONT_8:    o_continuous = 1'b1;
      ASI_MODE_SINGLE:                         o_single     = 1'b1;
      ASI_MODE_SINGLE_8X:                      o_single_8x  = 1'b1;
      ASI_MODE_FAST:                           o_fast       = 1'b1;
      ASI_MODE_BURST:                          o_burst      = 1'b1;
      ASI_MODE_SLEEP:                          o_sleep      = 1'b1;
      default:                                 o_reserved   = 1'b1;
    endcase
  end

endmodule : asi_mode_decode

// ===== asi_delay_timer.sv
// asi_delay_timer: counts a fixed number of cycles after a start pulse.
// assumes start is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/100ps
module asi_delay_timer #(
  parameter int CYCLES = 100000
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_resetn,
  // control
  input  wire logic i_start,
  // status
  output logic      o_done
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic          run_q;
  logic          done_q;

  wire at_last = run_q && (cnt_q == LAST);

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else if (i_start) begin
      cnt_q  <= '0;
      run_q  <= 1'b1;
      done_q <= 1'b0;
    end else if (at_last) begin
      run_q  <= 1'b0;
      done_q <= 1'b1;
    end else if (run_q) begin
      cnt_q  <= cnt_q + CW'(1);
    end
  end

  assign o_done = done_q;

endmodule : asi_delay_timer

// ===== asi_active_image_checker.sv
// asi_active_image_checker: port-level checks on the active image block.
// assumes a bind to asi_active_image and a short VALID_CYCLES.
`timescale 1ns/100ps
module asi_active_image_checker
  import asi_pkg::*;
#(
  parameter int VALID_CYCLES = ASI_VALID_CYCLES
) (
  // clock, reset and requests
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic [15:0] i_pend_ctrl,
  input wire logic [15:0] i_pend_range,
  input wire logic        i_refresh,
  input wire logic        i_cycle_done,
  input wire logic        i_pin1_level,
  input wire logic        i_no_skip,
  input wire logic        i_rd_en,
  input wire logic [7:0]  i_rd_addr,
  // design outputs
  input wire logic [15:0] o_rd_data,
  input wire logic        o_rd_ack,
  input wire logic [15:0] o_ctrl_image,
  input wire logic [15:0] o_range_image,
  input wire logic        o_image_valid,
  input wire logic        o_rate_change_pending,
  input wire logic        o_adaptive,
  input wire logic        o_continuous,
  input wire logic        o_single,
  input wire logic        o_single_8x,
  input wire logic        o_fast,
  input wire logic        o_burst,
  input wire logic        o_sleep,
  input wire logic [1:0]  o_rate,
  input wire logic [1:0]  o_pin1_role,
  input wire logic [3:0]  o_ch_active,
  input wire logic [3:0]  o_addr_skip
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  // ----------------------------------------------------------------
  // cycles since refresh, and whether a change had to wait
  // ----------------------------------------------------------------
  logic [7:0] cnt_q;
  logic       pend_seen_q;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q       <= 8'hFF;
      pend_seen_q <= 1'b0;
    end else begin
      cnt_q       <= i_refresh ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hFF};
      pend_seen_q <= !i_refresh && (pend_seen_q || o_rate_change_pending);
    end
  end

  // channel 1 sits in field bit 7 but in output bit 0
  wire [3:0] off_rev = {o_ctrl_image[4], o_ctrl_image[5], o_ctrl_image[6], o_ctrl_image[7]};

  sequence s_rd_ctrl;
    i_rd_en && i_rd_addr == ASI_OFS_ACT_CTRL && !i_refresh && !i_cycle_done;
  endsequence
  sequence s_ref_now;
    i_refresh && (i_pend_ctrl[15:12] == o_ctrl_image[15:12] || o_ctrl_image[15:12] == 4'hF);
  endsequence
  sequence s_ref_wait;
    i_refresh && i_pend_ctrl[15:12] != o_ctrl_image[15:12] && o_ctrl_image[15:12] != 4'hF;
  endsequence

  AST_RD_CTRL: assert property (s_rd_ctrl |=> o_rd_ack && o_rd_data == $past(o_ctrl_image))
    else $error("control image read mismatch");
  AST_RD_NONE: assert property (i_rd_en && i_rd_addr != ASI_OFS_ACT_CTRL
    && i_rd_addr != ASI_OFS_ACT_RANGE |=> o_rd_data == 16'h0000)
    else $error("unmapped read not zero");
  AST_LOW_ZERO: assert property (o_ctrl_image[3:0] == 4'h0)
    else $error("low control bits set");
  AST_HOLD: assert property (!$stable(o_ctrl_image) |-> $past(i_refresh) || $past(i_cycle_done))
    else $error("control image changed without cause");
  AST_RANGE: assert property (i_refresh |=> o_range_image == $past(i_pend_range))
    else $error("range image not loaded");
  AST_NOW: assert property (s_ref_now |=> o_ctrl_image == ($past(i_pend_ctrl) & ASI_CTRL_MASK)
    && !o_image_valid)
    else $error("control image not loaded whole");
  AST_DEFER: assert property (s_ref_wait |=> $stable(o_ctrl_image) && o_rate_change_pending)
    else $error("rate change not deferred");
  AST_VALID: assert property ($rose(o_image_valid) && !pend_seen_q |-> cnt_q == 8'(VALID_CYCLES))
    else $error("valid rose at wrong time");
  AST_ONEHOT: assert property ($onehot0({o_adaptive, o_continuous, o_single, o_single_8x,
    o_fast, o_burst, o_sleep}))
    else $error("mode flags not exclusive");
  AST_SLEEP: assert property (o_ctrl_image[15:12] == 4'hF |=> o_sleep && !o_burst)
    else $error("sleep code not decoded");
  AST_OVR: assert property (i_pin1_level && o_pin1_role == ASI_PIN_SLOW && o_adaptive
    && $stable(o_ctrl_image) |=> o_rate == ASI_RATE_8SPS)
    else $error("rate override ignored");
  AST_CHAN: assert property (1'b1 |=> o_ch_active == ~$past(off_rev)
    && o_addr_skip == ($past(off_rev) & ~{4{$past(i_no_skip)}}))
    else $error("channel outputs wrong");
endmodule : asi_active_image_checker

bind asi_active_image asi_active_image_checker #(.VALID_CYCLES(VALID_CYCLES)) u_chk (
  .i_clock, .i_resetn, .i_pend_ctrl, .i_pend_range, .i_refresh, .i_cycle_done,
  .i_pin1_level, .i_no_skip, .i_rd_en, .i_rd_addr, .o_rd_data, .o_rd_ack, .o_ctrl_image,
  .o_range_image, .o_image_valid, .o_rate_change_pending, .o_adaptive, .o_continuous,
  .o_single, .o_single_8x, .o_fast, .o_burst, .o_sleep, .o_rate, .o_pin1_role,
  .o_ch_active, .o_addr_skip
);

// ===== asi_conv_model.sv
// asi_conv_model: stand-in for the conversion sequencer ending its cycles.
// assumes the design samples the pulse on the rising edge.
`timescale 1ns/100ps
module asi_conv_model #(
  parameter int PERIOD = 13
) (
  input  wire logic i_clock,
  input  wire logic i_resetn,
  input  wire logic i_stall,
  output logic      o_cycle_done
);
  int cnt;
  // launched on the falling edge so the pulse is settled at sampling
  always @(negedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt          = 0;
      o_cycle_done = 1'b0;
    end else begin
      cnt          = (cnt >= PERIOD - 1) ? 0 : cnt + 1;
      o_cycle_done = !i_stall && (cnt == 0);
    end
  end
endmodule : asi_conv_model

// ===== asi_active_image_tb_top.sv
// asi_active_image_tb_top: directed bench for the active image registers.
// assumes the checker is bound by its own file and VALID_CYCLES is short.
`timescale 1ns/100ps
module asi_active_image_tb_top;
  import asi_pkg::*;
  localparam int VC = 20;
  logic        i_clock = 1'b0;
  logic        i_resetn = 1'b0;
  logic [15:0] i_pend_ctrl = 16'h0000;
  logic [15:0] i_pend_range = 16'h0000;
  logic        i_refresh = 1'b0;
  logic        i_pin1_level = 1'b0;
  logic        i_pin2_level = 1'b0;
  logic        i_no_skip = 1'b0;
  logic        i_rd_en = 1'b0;
  logic [7:0]  i_rd_addr = 8'h00;
  logic        i_stall = 1'b0;
  logic        i_cycle_done;
  logic [15:0] o_rd_data, o_ctrl_image, o_range_image;
  logic        o_rd_ack, o_image_valid, o_rate_change_pending, o_adaptive, o_continuous;
  logic        o_single, o_single_8x, o_fast, o_burst, o_sleep, o_pin1_gpio, o_pin2_gpio;
  logic [1:0]  o_rate, o_pin1_role, o_pin2_role;
  logic [3:0]  o_ch_active, o_addr_skip;
  int          n_errors = 0;
  int          checks = 0;

  always #5 i_clock = ~i_clock;

  asi_conv_model #(.PERIOD(13)) i_conv (.i_clock, .i_resetn, .i_stall,
    .o_cycle_done(i_cycle_done));
  asi_active_image #(.NUM_CHANNELS(4), .VALID_CYCLES(VC)) i_dut (
    .i_clock, .i_resetn, .i_pend_ctrl, .i_pend_range, .i_refresh, .i_cycle_done,
    .i_pin1_level, .i_pin2_level, .i_no_skip, .i_rd_en, .i_rd_addr, .o_rd_data, .o_rd_ack,
    .o_ctrl_image, .o_range_image, .o_image_valid, .o_rate_change_pending, .o_adaptive,
    .o_continuous, .o_single, .o_single_8x, .o_fast, .o_burst, .o_sleep, .o_rate,
    .o_pin1_role, .o_pin2_role, .o_pin1_gpio, .o_pin2_gpio, .o_ch_active, .o_addr_skip);

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
    @(negedge i_clock);
    i_rd_en   = 1'b1;
    i_rd_addr = addr;
    @(negedge i_clock);
    i_rd_en = 1'b0;
    chk("read ack", 16'h0001, {15'h0000, o_rd_ack});
    chk("read data", exp, o_rd_data);
  endtask : rd

  task automatic refresh(input logic [15:0] ctrl, input logic [15:0] range);
    @(negedge i_clock);
    i_pend_ctrl  = ctrl;
    i_pend_range = range;
    i_refresh    = 1'b1;
    @(negedge i_clock);
    i_refresh = 1'b0;
  endtask : refresh

  // waits for a deferred load, then one more cycle for the decode
  task automatic settle();
    for (int k = 0; k < 40 && o_rate_change_pending !== 1'b0; k++) @(negedge i_clock);
    chk("pending clear", 16'h0000, {15'h0000, o_rate_change_pending});
    @(negedge i_clock);
  endtask : settle

  function automatic logic [15:0] flags(input logic [3:0] c);
    return {7'h00, c < 4'h4, c[3:2] == 2'b01, c == 4'h8, c == 4'h9, c == 4'hA, c == 4'hB,
      c == 4'hF, (c < 4'h8) ? c[1:0] : 2'h0};
  endfunction : flags

  function automatic logic [15:0] seen(input logic [3:0] c);
    return {7'h00, o_adaptive, o_continuous, o_single, o_single_8x, o_fast, o_burst,
      o_sleep, (c < 4'h8) ? o_rate : 2'h0};
  endfunction : seen

  task automatic results();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge i_clock);
    i_resetn = 1'b1;
    i_pend_ctrl = 16'hBFF0;
    rd(ASI_OFS_ACT_CTRL, 16'h0700);
    rd(ASI_OFS_ACT_RANGE, 16'h0000);
    rd(8'h23, 16'h0000);
    rd(ASI_OFS_PEND_CTRL, 16'h0000);
    chk("pin roles", 16'h0031, {10'h000, o_pin1_role, 2'h0, o_pin2_role});
    chk("gpio roles", 16'h0001, {14'h0000, o_pin1_gpio, o_pin2_gpio});
    chk("mode flags", flags(4'h0), seen(4'h0));
    chk("valid", 16'h0000, {15'h0000, o_image_valid});
    refresh(16'h0F5F, 16'h5A3C);
    repeat (VC - 1) @(negedge i_clock);
    chk("valid early", 16'h0000, {15'h0000, o_image_valid});
    @(negedge i_clock);
    chk("valid", 16'h0001, {15'h0000, o_image_valid});
    rd(ASI_OFS_ACT_CTRL, 16'h0F50);
    rd(ASI_OFS_ACT_RANGE, 16'h5A3C);
    for (int c = 1; c < 16; c++) begin
      if (c >= 12 && c <= 14) continue;
      i_stall <= (c == 1);
      refresh({c[3:0], 12'hF50}, 16'h0000);
      chk("rate wait", 16'h0001, {15'h0000, o_rate_change_pending});
      if (c == 1) begin
        repeat (30) @(negedge i_clock);
        rd(ASI_OFS_ACT_CTRL, 16'h0F50);
        i_stall <= 1'b0;
      end
      settle();
      rd(ASI_OFS_ACT_CTRL, {c[3:0], 12'hF50});
      chk("mode flags", flags(c[3:0]), seen(c[3:0]));
    end
    // leaving sleep takes effect at once
    refresh(16'hCF50, 16'h0000);
    rd(ASI_OFS_ACT_CTRL, 16'hCF50);
    settle();
    chk("reserved flags", flags(4'hC), seen(4'hC));
    refresh(16'h0F50, 16'h0000);
    settle();
    for (int p = 0; p < 2; p++) begin
      i_pin1_level = (p == 0);
      i_pin2_level = (p == 1);
      repeat (2) @(negedge i_clock);
      chk("rate override", 16'h0003, {14'h0000, o_rate});
    end
    i_pin2_level = 1'b0;
    repeat (2) @(negedge i_clock);
    chk("rate", 16'h0000, {14'h0000, o_rate});
    chk("channels", 16'h005A, {8'h00, o_ch_active, o_addr_skip});
    i_no_skip = 1'b1;
    repeat (2) @(negedge i_clock);
    chk("channels", 16'h0050, {8'h00, o_ch_active, o_addr_skip});
    // pin 1 as alert, pin 2 as general output: no override from pin 1
    refresh(16'h0850, 16'h0000);
    i_pin1_level = 1'b1;
    repeat (2) @(negedge i_clock);
    chk("pin roles", 16'h0002, {10'h000, o_pin1_role, 2'h0, o_pin2_role});
    chk("gpio roles", 16'h0001, {14'h0000, o_pin1_gpio, o_pin2_gpio});
    chk("rate", 16'h0000, {14'h0000, o_rate});
    i_pin1_level = 1'b0;
    i_resetn = 1'b0;
    repeat (2) @(negedge i_clock);
    i_resetn = 1'b1;
    rd(ASI_OFS_ACT_CTRL, 16'h0700);
    chk("valid", 16'h0000, {15'h0000, o_image_valid});
    results();
  end

  // the tests need well under 3000 cycles
  initial begin
    #100000;
    n_errors++;
    results();
  end
endmodule : asi_active_image_tb_top
